// ---- logic/efh_pkg.sv ----
package efh_pkg;
   localparam int WORD_W = 4;
   localparam int DEV_WORDS = 16;
   localparam int BUF_DEPTH = 32;
   localparam int CNT_W = 5;
   localparam int CLK_PERIOD_NS = 25;
   // Pin timing figures in ns, and synchroniser depth in stages
   localparam int MC_PULSE_NS = 100;
   localparam int SI_HIGH_NS = 120;
   localparam int SO_HIGH_NS = 180;
   localparam int FLAG_FALL_NS = 315;
   localparam int SYNC_STAGES = 2;
   // Least times round up to whole cycles
   localparam logic [CNT_W-1:0] MC_CYC =
      CNT_W'((MC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] SI_HIGH_CYC =
      CNT_W'((SI_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] SO_HIGH_CYC =
      CNT_W'((SO_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] SETTLE_CYC =
      CNT_W'((FLAG_FALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
   localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

   // Pins driven into the device
   typedef struct packed {
      logic master_clear;
      logic shift_in;
      logic shift_out;
      logic out_en_n;
      logic [WORD_W-1:0] write_word_bus;
   } efh_pins_t;

   // Pins coming back from the device
   typedef struct packed {
      logic input_ready;
      logic output_ready_flag;
      logic [WORD_W-1:0] read_word_bus;
   } efh_flags_t;

   typedef enum logic [1:0] {I_CLEAR, I_RUN} efh_init_t;
   typedef enum logic [1:0] {W_IDLE, W_SETUP, W_HIGH, W_LOW} efh_wr_t;
   typedef enum logic [1:0] {R_IDLE, R_HIGH, R_LOW} efh_rd_t;
endpackage

// ---- logic/efh_host.sv ----
`timescale 1ns/1ps
// Write buffer ahead of the shift-in engine
module efh_fifo
   import efh_pkg::*;
#(
   parameter int WIDTH = WORD_W,
   parameter int DEPTH = BUF_DEPTH
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic [AW:0] next_wr_ptr;
   logic [AW:0] next_rd_ptr;
   logic push;
   logic pop;

   // Full when pointers differ only in the wrap bit
   always_comb begin
      in_ready_o = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
      out_valid_o = (wr_ptr != rd_ptr);
      out_data_o = mem[rd_ptr[AW-1:0]];
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
   end

   // Pointers reset; storage needs no reset
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data_i;
      end
   end
endmodule

`timescale 1ns/1ps
// Host that drives the elastic store through its pins
module efh_host
   import efh_pkg::*;
#(
   parameter int DEPTH = BUF_DEPTH
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic wr_valid_i,
   input wire logic [WORD_W-1:0] wr_data_i,
   output logic wr_ready_o,
   output logic rd_valid_o,
   output logic [WORD_W-1:0] rd_data_o,
   input wire logic rd_ready_i,
   output efh_pins_t pins_o,
   input wire efh_flags_t flags_i
);
   efh_flags_t sync1;
   efh_flags_t sync2;
   efh_init_t istate;
   efh_init_t next_istate;
   efh_wr_t wstate;
   efh_wr_t next_wstate;
   efh_rd_t rstate;
   efh_rd_t next_rstate;
   logic [CNT_W-1:0] icnt;
   logic [CNT_W-1:0] next_icnt;
   logic [CNT_W-1:0] wcnt;
   logic [CNT_W-1:0] next_wcnt;
   logic [CNT_W-1:0] rcnt;
   logic [CNT_W-1:0] next_rcnt;
   efh_pins_t next_pins;
   logic out_valid;
   logic next_out_valid;
   logic [WORD_W-1:0] out_data;
   logic [WORD_W-1:0] next_out_data;
   logic buf_valid;
   logic buf_pop;
   logic [WORD_W-1:0] buf_data;
   logic running;

   efh_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(DEPTH)
   ) u_buf (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .in_valid_i(wr_valid_i),
      .in_data_i(wr_data_i),
      .in_ready_o(wr_ready_o),
      .out_valid_o(buf_valid),
      .out_data_o(buf_data),
      .out_ready_i(buf_pop)
   );

   // Device pins are asynchronous to us: two stages first
   always_ff @(posedge core_clk_i) begin
      sync1 <= flags_i;
      sync2 <= sync1;
   end

   assign running = (istate == I_RUN);
   assign rd_valid_o = out_valid;
   assign rd_data_o = out_data;

   // Next values for start-up, writer and reader
   always_comb begin
      next_istate = istate;
      next_icnt = icnt;
      next_wstate = wstate;
      next_wcnt = wcnt;
      next_rstate = rstate;
      next_rcnt = rcnt;
      next_out_valid = out_valid && !rd_ready_i;
      next_out_data = out_data;
      next_pins = pins_o;
      buf_pop = 1'b0;
      // Clear pulse ahead of any strobe
      unique case (istate)
         I_CLEAR: begin
            if (icnt == CNT_ZERO) begin
               next_istate = I_RUN;
            end else begin
               next_icnt = icnt - CNT_ONE;
            end
         end
         I_RUN: begin
         end
      endcase
      // Shift only when input-ready says the first stage is free
      unique case (wstate)
         W_IDLE: begin
            if (running && buf_valid && sync2.input_ready) begin
               buf_pop = 1'b1;
               next_pins.write_word_bus = buf_data;
               next_wstate = W_SETUP;
            end
         end
         W_SETUP: begin
            next_wcnt = SI_HIGH_CYC - CNT_ONE;
            next_wstate = W_HIGH;
         end
         W_HIGH: begin
            if (wcnt == CNT_ZERO) begin
               next_wcnt = SETTLE_CYC - CNT_ONE;
               next_wstate = W_LOW;
            end else begin
               next_wcnt = wcnt - CNT_ONE;
            end
         end
         W_LOW: begin
            // Stale ready must drain through the synchroniser
            if (wcnt == CNT_ZERO) begin
               next_wstate = W_IDLE;
            end else begin
               next_wcnt = wcnt - CNT_ONE;
            end
         end
      endcase
      // Reader keeps shift-out low when idle so no auto removal
      unique case (rstate)
         R_IDLE: begin
            if (running && sync2.output_ready_flag && !out_valid) begin
               next_out_data = sync2.read_word_bus;
               next_out_valid = 1'b1;
               next_rcnt = SO_HIGH_CYC - CNT_ONE;
               next_rstate = R_HIGH;
            end
         end
         R_HIGH: begin
            if (rcnt == CNT_ZERO) begin
               next_rcnt = SETTLE_CYC - CNT_ONE;
               next_rstate = R_LOW;
            end else begin
               next_rcnt = rcnt - CNT_ONE;
            end
         end
         R_LOW: begin
            if (rcnt == CNT_ZERO) begin
               next_rstate = R_IDLE;
            end else begin
               next_rcnt = rcnt - CNT_ONE;
            end
         end
      endcase
      next_pins.master_clear = (next_istate == I_CLEAR);
      next_pins.out_en_n = (next_istate == I_CLEAR);
      next_pins.shift_in = (next_wstate == W_HIGH);
      next_pins.shift_out = (next_rstate == R_HIGH);
   end

   // Registers only; reset holds the device cleared
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         istate <= I_CLEAR;
         icnt <= MC_CYC - CNT_ONE;
         wstate <= W_IDLE;
         wcnt <= CNT_ZERO;
         rstate <= R_IDLE;
         rcnt <= CNT_ZERO;
         out_valid <= 1'b0;
         out_data <= '0;
         pins_o <= '{master_clear: 1'b1, shift_in: 1'b0, shift_out: 1'b0,
                     out_en_n: 1'b1, write_word_bus: '0};
      end else begin
         istate <= next_istate;
         icnt <= next_icnt;
         wstate <= next_wstate;
         wcnt <= next_wcnt;
         rstate <= next_rstate;
         rcnt <= next_rcnt;
         out_valid <= next_out_valid;
         out_data <= next_out_data;
         pins_o <= next_pins;
      end
   end

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);

   sequence seq_si_pulse;
      pins_o.shift_in [*5] ##1 !pins_o.shift_in [*8];
   endsequence

   sequence seq_so_pulse;
      pins_o.shift_out [*8] ##1 !pins_o.shift_out [*8];
   endsequence

   AST_MC_PULSE: assert property (
      $fell(reset_i) |-> pins_o.master_clear [*4] ##1 !pins_o.master_clear)
      else $error("master clear pulse has wrong length");
   AST_NO_SHIFT_IN_CLEAR: assert property (
      pins_o.master_clear |-> !pins_o.shift_in && !pins_o.shift_out)
      else $error("strobe raised during master clear");
   AST_SI_ON_READY: assert property (
      $rose(pins_o.shift_in) |-> $past(sync2.input_ready, 2))
      else $error("shift-in raised without input-ready");
   AST_SI_PULSE: assert property (
      $rose(pins_o.shift_in) |-> seq_si_pulse)
      else $error("shift-in pulse shape wrong");
   AST_WORD_STABLE: assert property (
      pins_o.shift_in |-> $stable(pins_o.write_word_bus))
      else $error("write word moved during shift-in");
   AST_SO_ON_READY: assert property (
      $rose(pins_o.shift_out) |-> out_valid && out_data == $past(sync2.read_word_bus))
      else $error("shift-out without captured word");
   AST_SO_PULSE: assert property (
      $rose(pins_o.shift_out) |-> seq_so_pulse)
      else $error("shift-out pulse shape wrong");
   AST_OE_RUN: assert property (
      $fell(pins_o.master_clear) |-> !pins_o.out_en_n [*8])
      else $error("output enable not low after clear");
endmodule

// ---- tb/efh_dev_model.sv ----
`timescale 1ns/1ps
// Behavioural elastic store, ripple time set by the bench
module efh_dev_model
   import efh_pkg::*;
(
   input wire efh_pins_t pins_i,
   input var int ripple_ns_i,
   output efh_flags_t flags_o
);
   logic [WORD_W-1:0] store[$];
   logic [WORD_W-1:0] first_word;
   logic [WORD_W-1:0] out_word = 4'h9;
   logic in_rdy = 1'b1;
   logic out_rdy = 1'b0;
   logic first_full = 1'b0;

   // Released bus shows the inverted word, never a stale copy
   assign flags_o = {in_rdy, out_rdy, pins_i.out_en_n ? ~out_word : out_word};

   task automatic capture();
      first_word = pins_i.write_word_bus;
      first_full = 1'b1;
      #5 in_rdy = 1'b0;
   endtask

   // Clear empties control stages, output word kept
   always @(posedge pins_i.master_clear) begin
      store.delete();
      first_full = 1'b0;
      in_rdy = 1'b1;
      out_rdy = 1'b0;
   end
   always @(negedge pins_i.master_clear) if (pins_i.shift_in) capture();
   always @(posedge pins_i.shift_in) if (!pins_i.master_clear) capture();

   // Word leaves the first stage only after the strobe falls
   always @(negedge pins_i.shift_in) begin
      if (first_full && !pins_i.master_clear) begin
         #(ripple_ns_i);
         store.push_back(first_word);
         first_full = 1'b0;
         in_rdy = store.size() < DEV_WORDS;
         if (!out_rdy && store.size() == 1) begin
            out_word = store[0];
            out_rdy = 1'b1;
         end
      end
   end

   // Falling shift-out drops the flag, then refills
   always @(negedge pins_i.shift_out) begin
      if (out_rdy && !pins_i.master_clear) begin
         #10 out_rdy = 1'b0;
         void'(store.pop_front());
         #(ripple_ns_i);
         if (!first_full && store.size() < DEV_WORDS) in_rdy = 1'b1;
         if (store.size() > 0) begin
            out_word = store[0];
            out_rdy = 1'b1;
         end
      end
   end
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
// User streams on one side, store model beyond the pins
module tb;
   import efh_pkg::*;
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic wr_valid_i = 1'b0;
   logic [WORD_W-1:0] wr_data_i = 4'h0;
   logic rd_ready_i = 1'b1;
   logic wr_ready_o;
   logic rd_valid_o;
   logic [WORD_W-1:0] rd_data_o;
   efh_pins_t pins;
   efh_flags_t flags;
   int ripple_ns = 200;
   int rd_mode = 0;
   int seed = 85271;
   int miscompares = 0;
   int num_checks = 0;
   logic [WORD_W-1:0] exp_q[$];

   always #(CLK_PERIOD_NS / 2.0) core_clk_i = ~core_clk_i;

   efh_host #(.DEPTH(BUF_DEPTH)) efh_host_i (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .wr_valid_i(wr_valid_i),
      .wr_data_i(wr_data_i), .wr_ready_o(wr_ready_o), .rd_valid_o(rd_valid_o),
      .rd_data_o(rd_data_o), .rd_ready_i(rd_ready_i), .pins_o(pins), .flags_i(flags));
   efh_dev_model efh_dev_model_i (.pins_i(pins), .ripple_ns_i(ripple_ns), .flags_o(flags));

   task automatic note_bad(input string msg);
      miscompares++;
      $display("mismatch at %0t: %s", $time, msg);
   endtask

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Ready is combinational, so it is judged at the falling edge
   task automatic send(input int n);
      repeat (n) begin
         wr_valid_i <= 1'b1;
         wr_data_i <= WORD_W'($random(seed));
         do @(negedge core_clk_i); while (wr_ready_o !== 1'b1);
         exp_q.push_back(wr_data_i);
         @(posedge core_clk_i);
      end
      wr_valid_i <= 1'b0;
   endtask

   task automatic drain(input string name);
      for (int i = 0; i < 20000 && exp_q.size() > 0; i++) @(posedge core_clk_i);
      repeat (40) @(posedge core_clk_i);
      num_checks++;
      if (exp_q.size() != 0) note_bad("words lost in the store");
      $display("test %s done", name);
   endtask

   // Reader back-pressure: 0 free, 1 stalled, 2 random
   always @(posedge core_clk_i) begin
      rd_ready_i <= (rd_mode == 0) || (rd_mode == 2 && $random(seed) % 3 != 0);
   end

   // Each word taken is matched with the oldest note
   always @(posedge core_clk_i) begin
      if (!reset_i && rd_valid_o === 1'b1 && rd_ready_i === 1'b1) begin
         num_checks++;
         if (exp_q.size() == 0) note_bad("word with nothing expected");
         else if (rd_data_o !== exp_q.pop_front()) note_bad("word out of order");
      end
   end

   initial begin
      repeat (16) @(posedge core_clk_i);
      reset_i <= 1'b0;
      repeat (10) @(posedge core_clk_i);
      num_checks++;
      if (pins.master_clear !== 1'b0 || pins.out_en_n !== 1'b0) note_bad("start pins");
      // Prompt store, free reader
      send(20);
      drain("order");
      // Slow ripple, reader stalled for 5000 cycles, then the write buffer must refuse
      ripple_ns <= 3000;
      rd_mode <= 1;
      fork
         send(60);
         begin
            repeat (5000) @(posedge core_clk_i);
            num_checks++;
            if (wr_ready_o !== 1'b0) note_bad("full path still accepts");
            rd_mode <= 2;
         end
      join
      drain("fill");
      // Clear in mid-run with words parked in the store
      ripple_ns <= 200;
      rd_mode <= 1;
      send(5);
      repeat (600) @(posedge core_clk_i);
      reset_i <= 1'b1;
      repeat (16) @(posedge core_clk_i);
      num_checks++;
      if (pins.master_clear !== 1'b1 || rd_valid_o !== 1'b0) note_bad("clear pins");
      exp_q.delete();
      reset_i <= 1'b0;
      rd_mode <= 2;
      send(6);
      drain("reset");
      wrap_up();
   end

   // Whole run needs about 15000 cycles; six times that is a hang
   initial begin
      repeat (90000) @(posedge core_clk_i);
      note_bad("run timed out");
      wrap_up();
   end
endmodule
